//--- src/emb_bus_if.sv
// Core side of the external memory bus with internal SRAM and test port lock
`timescale 1ns/1ns
module emb_bus_if (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // Core request
   input wire logic REQ_VALID,
   input wire logic [1:0] REQ_SPACE,
   input wire logic REQ_WRITE,
   input wire logic [15:0] REQ_ADDR,
   input wire logic [7:0] REQ_WDATA,
   output logic REQ_READY,
   output logic RSP_VALID,
   output logic [7:0] RSP_RDATA,
   // External bus pins
   input wire logic [7:0] MUXED_ADDR_DATA_LOW_IN,
   output logic [7:0] MUXED_ADDR_DATA_LOW_OUT,
   output logic MUXED_ADDR_DATA_LOW_OE_N,
   output logic [7:0] HIGH_ADDR_LINES,
   output logic READ_STROBE_N,
   output logic WRITE_STROBE_N,
   output logic PROGRAM_FETCH_STROBE_N,
   output logic ADDR_LATCH,
   output logic RESET_OUT_N,
   // Test port
   input wire logic TEST_REQ,
   input wire logic [2:0] TEST_OP,
   output logic TEST_ACK,
   output logic TEST_DENY,
   output logic TEST_LOCKED,
   output logic NV_PROG_GO,
   output logic ERASE_ALL_GO,
   output logic DBG_GO,
   output logic [2:0] DBG_CMD
);
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_HOLD, ST_STROBE, ST_INT, ST_INT_DONE} emb_st_e;
   emb_st_e st_r, st_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [1:0] space_r, space_nxt;
   logic [15:0] addr_r, addr_nxt;
   logic [7:0] wdata_r, wdata_nxt, rsp_rdata_r, rsp_rdata_nxt;
   logic [7:0] ad_out_r, ad_out_nxt, hi_r, hi_nxt;
   logic write_r, write_nxt, ready_r, ready_nxt, rsp_valid_r, rsp_valid_nxt;
   logic ad_oe_n_r, ad_oe_n_nxt, latch_r, latch_nxt;
   logic rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt, fetch_n_r, fetch_n_nxt;
   logic [7:0] ad_s1_r, ad_s2_r, sram_rdata;
   logic rst_out_n_r, accept, in_sram;
   // Pin data from the far die passes two flops before anything reads it;
   // the companion die is released one cycle after this block leaves reset
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ad_s1_r <= 8'h00;
         ad_s2_r <= 8'h00;
         rst_out_n_r <= 1'b0;
      end else begin
         ad_s1_r <= MUXED_ADDR_DATA_LOW_IN;
         ad_s2_r <= ad_s1_r;
         rst_out_n_r <= 1'b1;
      end
   end
   assign accept = REQ_VALID && ready_r;
   // Only the first 384 bytes exist; higher internal addresses read zero
   assign in_sram = addr_r < emb_pkg::SRAM_LIMIT;
   // Bus sequencer next state
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      space_nxt = space_r;
      write_nxt = write_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      rsp_valid_nxt = 1'b0;
      rsp_rdata_nxt = rsp_rdata_r;
      ad_out_nxt = ad_out_r;
      ad_oe_n_nxt = ad_oe_n_r;
      hi_nxt = hi_r;
      rd_n_nxt = 1'b1;
      wr_n_nxt = 1'b1;
      fetch_n_nxt = 1'b1;
      latch_nxt = 1'b0;
      unique case (st_r)
         ST_IDLE: begin
            ad_oe_n_nxt = 1'b1;
            if (accept) begin
               space_nxt = REQ_SPACE;
               write_nxt = REQ_WRITE && (REQ_SPACE != emb_pkg::SPACE_PROG);
               addr_nxt = REQ_ADDR;
               wdata_nxt = REQ_WDATA;
               if (REQ_SPACE == emb_pkg::SPACE_INT) begin
                  st_nxt = ST_INT;
               end else begin
                  // Full 16 bit address in either space, no extension bits
                  st_nxt = ST_ADDR;
                  cnt_nxt = emb_pkg::LATCH_CYC;
                  latch_nxt = 1'b1;
                  ad_out_nxt = REQ_ADDR[7:0];
                  ad_oe_n_nxt = 1'b0;
                  hi_nxt = REQ_ADDR[15:8];
               end
            end
         end
         ST_ADDR: begin
            if (cnt_r == emb_pkg::CNT_ONE) begin
               st_nxt = ST_HOLD;
            end else begin
               cnt_nxt = cnt_r - 3'h1;
               latch_nxt = 1'b1;
            end
         end
         ST_HOLD: begin
            // Address stays one cycle after the latch falls so the far side captures it
            st_nxt = ST_STROBE;
            cnt_nxt = emb_pkg::STROBE_CYC;
            fetch_n_nxt = space_r != emb_pkg::SPACE_PROG;
            rd_n_nxt = !(space_r == emb_pkg::SPACE_DATA && !write_r);
            wr_n_nxt = !(space_r == emb_pkg::SPACE_DATA && write_r);
            ad_out_nxt = write_r ? wdata_r : emb_pkg::BYTE_ZERO;
            ad_oe_n_nxt = !write_r;
         end
         ST_STROBE: begin
            if (cnt_r == emb_pkg::CNT_ONE) begin
               st_nxt = ST_IDLE;
               ad_oe_n_nxt = 1'b1;
               rsp_valid_nxt = 1'b1;
               // Synchroniser lag means data is taken from mid-strobe
               rsp_rdata_nxt = write_r ? emb_pkg::BYTE_ZERO : ad_s2_r;
            end else begin
               cnt_nxt = cnt_r - 3'h1;
               fetch_n_nxt = fetch_n_r;
               rd_n_nxt = rd_n_r;
               wr_n_nxt = wr_n_r;
            end
         end
         ST_INT: st_nxt = ST_INT_DONE;
         ST_INT_DONE: begin
            st_nxt = ST_IDLE;
            rsp_valid_nxt = 1'b1;
            rsp_rdata_nxt = (write_r || !in_sram) ? emb_pkg::BYTE_ZERO : sram_rdata;
         end
      endcase
      ready_nxt = (st_nxt == ST_IDLE);
   end
   // Bus sequencer registers
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_r <= ST_IDLE;
         cnt_r <= 3'h0;
         space_r <= 2'h0;
         write_r <= 1'b0;
         addr_r <= 16'h0000;
         wdata_r <= 8'h00;
         ready_r <= 1'b0;
         rsp_valid_r <= 1'b0;
         rsp_rdata_r <= 8'h00;
         ad_out_r <= 8'h00;
         ad_oe_n_r <= 1'b1;
         hi_r <= 8'h00;
         rd_n_r <= 1'b1;
         wr_n_r <= 1'b1;
         fetch_n_r <= 1'b1;
         latch_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         space_r <= space_nxt;
         write_r <= write_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         ready_r <= ready_nxt;
         rsp_valid_r <= rsp_valid_nxt;
         rsp_rdata_r <= rsp_rdata_nxt;
         ad_out_r <= ad_out_nxt;
         ad_oe_n_r <= ad_oe_n_nxt;
         hi_r <= hi_nxt;
         rd_n_r <= rd_n_nxt;
         wr_n_r <= wr_n_nxt;
         fetch_n_r <= fetch_n_nxt;
         latch_r <= latch_nxt;
      end
   end
   // Internal SRAM, accessed without touching the external strobes
   emb_sram u_sram (
      .CLK(CLK),
      .en(st_r == ST_INT && in_sram),
      .addr(addr_r[emb_pkg::SRAM_AW-1:0]),
      .we(write_r), .wdata(wdata_r), .rdata(sram_rdata)
   );
   // Test port: security lock and operation dispatch
   logic sec_r, sec_nxt;
   logic ack_r, ack_nxt, deny_r, deny_nxt;
   logic nv_r, nv_nxt, erase_r, erase_nxt, dbg_r, dbg_nxt;
   logic [2:0] dbg_cmd_r, dbg_cmd_nxt;
   always_comb begin
      sec_nxt = sec_r;
      ack_nxt = 1'b0;
      deny_nxt = 1'b0;
      nv_nxt = 1'b0;
      erase_nxt = 1'b0;
      dbg_nxt = 1'b0;
      dbg_cmd_nxt = dbg_cmd_r;
      if (TEST_REQ) begin
         if (TEST_OP == emb_pkg::OP_ERASE) begin
            // Erase is the one door left open, and it blanks everything
            sec_nxt = 1'b0;
            erase_nxt = 1'b1;
            ack_nxt = 1'b1;
         end else if (sec_r) begin
            deny_nxt = 1'b1;
         end else if (TEST_OP == emb_pkg::OP_LOCK) begin
            sec_nxt = 1'b1;
            ack_nxt = 1'b1;
         end else if (TEST_OP == emb_pkg::OP_NVPROG) begin
            nv_nxt = 1'b1;
            ack_nxt = 1'b1;
         end else if (TEST_OP <= emb_pkg::OP_TRACE) begin
            dbg_nxt = 1'b1;
            dbg_cmd_nxt = TEST_OP;
            ack_nxt = 1'b1;
         end else begin
            deny_nxt = 1'b1;
         end
      end
   end
   // Lock bit models the nonvolatile cell; it clears through erase and also on reset
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         {sec_r, ack_r, deny_r, nv_r, erase_r, dbg_r} <= 6'h00;
         dbg_cmd_r <= 3'h0;
      end else begin
         {sec_r, ack_r, deny_r} <= {sec_nxt, ack_nxt, deny_nxt};
         {nv_r, erase_r, dbg_r} <= {nv_nxt, erase_nxt, dbg_nxt};
         dbg_cmd_r <= dbg_cmd_nxt;
      end
   end
   // Outputs straight from flops
   assign {REQ_READY, RSP_VALID, RSP_RDATA} = {ready_r, rsp_valid_r, rsp_rdata_r};
   assign {MUXED_ADDR_DATA_LOW_OUT, MUXED_ADDR_DATA_LOW_OE_N} = {ad_out_r, ad_oe_n_r};
   assign {HIGH_ADDR_LINES, ADDR_LATCH, RESET_OUT_N} = {hi_r, latch_r, rst_out_n_r};
   assign {READ_STROBE_N, WRITE_STROBE_N, PROGRAM_FETCH_STROBE_N} = {rd_n_r, wr_n_r, fetch_n_r};
   assign {TEST_ACK, TEST_DENY, TEST_LOCKED} = {ack_r, deny_r, sec_r};
   assign {NV_PROG_GO, ERASE_ALL_GO, DBG_GO, DBG_CMD} = {nv_r, erase_r, dbg_r, dbg_cmd_r};
   // Checks
   a_fetch_prog_only: assert property (@(posedge CLK) disable iff (!RESET_N)
      !fetch_n_r |-> space_r == emb_pkg::SPACE_PROG && rd_n_r && wr_n_r)
      else $error("fetch strobe outside program access");
   a_read_data_only: assert property (@(posedge CLK) disable iff (!RESET_N)
      $fell(rd_n_r) |-> space_r == emb_pkg::SPACE_DATA && !write_r ##0 !rd_n_r [*4])
      else $error("read strobe wrong space or length");
   a_write_data_drive: assert property (@(posedge CLK) disable iff (!RESET_N)
      !wr_n_r |-> write_r && !ad_oe_n_r && ad_out_r == wdata_r)
      else $error("write strobe without data on lines");
   a_internal_quiet: assert property (@(posedge CLK) disable iff (!RESET_N)
      accept && REQ_SPACE == emb_pkg::SPACE_INT |=> (rd_n_r && wr_n_r && fetch_n_r) [*3])
      else $error("strobe active during internal access");
   a_latch_addr: assert property (@(posedge CLK) disable iff (!RESET_N)
      latch_r |-> !ad_oe_n_r && ad_out_r == addr_r[7:0] && hi_r == addr_r[15:8])
      else $error("latch without valid address");
   a_latch_fall_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
      $fell(latch_r) |-> ad_out_r == addr_r[7:0] && rd_n_r && wr_n_r && fetch_n_r)
      else $error("lines switched before latch fell");
   a_lock_refuses: assert property (@(posedge CLK) disable iff (!RESET_N)
      TEST_REQ && sec_r && TEST_OP != emb_pkg::OP_ERASE |=> deny_r && !ack_r && sec_r)
      else $error("locked port accepted access");
   a_erase_unlocks: assert property (@(posedge CLK) disable iff (!RESET_N)
      TEST_REQ && TEST_OP == emb_pkg::OP_ERASE |=> erase_r && !sec_r)
      else $error("erase did not clear lock");
   a_debug_dispatch: assert property (@(posedge CLK) disable iff (!RESET_N)
      TEST_REQ && !sec_r && TEST_OP == emb_pkg::OP_STEP |=> dbg_r && dbg_cmd_r == emb_pkg::OP_STEP)
      else $error("debug step not dispatched");
   a_sram_answer: assert property (@(posedge CLK) disable iff (!RESET_N)
      accept && REQ_SPACE == emb_pkg::SPACE_INT |-> ##3 rsp_valid_r)
      else $error("internal access answer late");
   c_prog_fetch: cover property (@(posedge CLK) disable iff (!RESET_N) $fell(fetch_n_r));
   c_data_write: cover property (@(posedge CLK) disable iff (!RESET_N) $fell(wr_n_r));
   c_int_read: cover property (@(posedge CLK) disable iff (!RESET_N) st_r == ST_INT && !write_r);
   c_locked_deny: cover property (@(posedge CLK) disable iff (!RESET_N) deny_r);
endmodule

//--- src/emb_pkg.sv
// Constants shared by the external memory bus interface and its SRAM
package emb_pkg;
   // Clock and bus timing
   localparam int CLK_MHZ = 250;
   localparam int LATCH_NS = 8;
   localparam int STROBE_NS = 16;
   localparam int LATCH_CYC_I = (LATCH_NS * CLK_MHZ + 999) / 1000;
   localparam int STROBE_CYC_I = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [2:0] LATCH_CYC = LATCH_CYC_I[2:0];
   localparam logic [2:0] STROBE_CYC = STROBE_CYC_I[2:0];
   localparam logic [2:0] CNT_ONE = 3'h1;
   // Address spaces and internal SRAM
   localparam int ADDR_W = 16;
   localparam int SRAM_BYTES = 384;
   localparam int SRAM_AW = 9;
   localparam logic [15:0] SRAM_LIMIT = 16'h0180;
   localparam logic [1:0] SPACE_INT = 2'h0;
   localparam logic [1:0] SPACE_PROG = 2'h1;
   localparam logic [1:0] SPACE_DATA = 2'h2;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // Test port operations
   localparam logic [2:0] OP_NVPROG = 3'h0;
   localparam logic [2:0] OP_BREAK = 3'h1;
   localparam logic [2:0] OP_STEP = 3'h2;
   localparam logic [2:0] OP_DISPLAY = 3'h3;
   localparam logic [2:0] OP_TRACE = 3'h4;
   localparam logic [2:0] OP_ERASE = 3'h5;
   localparam logic [2:0] OP_LOCK = 3'h6;
endpackage

//--- src/emb_sram.sv
// Internal 384 byte SRAM with registered read data
`timescale 1ns/1ns
module emb_sram (
   // Clock
   input wire logic CLK,
   // Access
   input wire logic en,
   input wire logic we,
   input wire logic [emb_pkg::SRAM_AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:emb_pkg::SRAM_BYTES-1];

   // No reset on the array; read data register updates only on enabled reads
   always_ff @(posedge CLK) begin
      if (en && we) begin
         mem[addr] <= wdata;
      end
      if (en && !we) begin
         rdata <= mem[addr];
      end
   end
endmodule

//--- bench/emb_companion_model.sv
// Companion die model: address decoder, program flash and data memory
`timescale 1ns/1ns
module emb_companion_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Bus from the core
   input wire logic latch,
   input wire logic [7:0] addr_hi,
   input wire logic [7:0] lo_out,
   input wire logic lo_oe_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic fetch_n,
   // Resolved level of the shared low byte
   output logic [7:0] wire_lo
);
   logic [15:0] lat_r;
   logic [7:0] last_r = 8'h00;
   logic [7:0] rd_val;
   logic [7:0] dmem [0:65535];
   logic [65535:0] dval = '0;
   // Address taken from the shared lines only while the latch strobe is high;
   // the core hands over 16 bits only, so any page register would extend them here
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lat_r <= 16'h0000;
      end else if (latch) begin
         lat_r <= {addr_hi, lo_out};
      end
   end
   // Data space is written only under the write strobe
   always @(posedge clk) begin
      if (!wr_n && !lo_oe_n) begin
         dmem[lat_r] <= lo_out;
         dval[lat_r] <= 1'b1;
      end
      last_r <= wire_lo;
   end
   // Program space answers to the fetch strobe only, data space to the read strobe
   always @* begin
      rd_val = 8'h00;
      if (!fetch_n) begin
         rd_val = lat_r[7:0] ^ lat_r[15:8] ^ 8'h5a;
      end else if (!rd_n && dval[lat_r]) begin
         rd_val = dmem[lat_r];
      end
      if (!lo_oe_n) begin
         wire_lo = lo_out;
      end else if (!fetch_n || !rd_n) begin
         wire_lo = rd_val;
      end else begin
         wire_lo = ~last_r; // Released lines toggle so stale data never looks valid
      end
   end
endmodule

//--- bench/ext_memory_bus_interface_test.sv
// Self-checking bench for the core side of the external memory bus
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin check_count++; if ((ex) !== (got)) begin failures++; \
   $display("BAD %s expected %h seen %h", nm, ex, got); end end
module ext_memory_bus_interface_test;
   logic CLK = 1'b0, RESET_N = 1'b0, REQ_VALID = 1'b0, REQ_WRITE = 1'b0, TEST_REQ = 1'b0;
   logic [1:0] REQ_SPACE = 2'h0;
   logic [15:0] REQ_ADDR = 16'h0000;
   logic [7:0] REQ_WDATA = 8'h00, lo_in, lo_out, hi, q;
   logic [2:0] TEST_OP = 3'h0, dbg_cmd;
   logic ready, rsp, oe_n, rd_n, wr_n, ps_n, ale, rst_out_n, ack, deny, locked, nv, er, dbg;
   logic [7:0] rdata;
   int failures = 0, check_count = 0, cyc = 0;
   emb_bus_if uut (.CLK(CLK), .RESET_N(RESET_N), .REQ_VALID(REQ_VALID), .REQ_SPACE(REQ_SPACE),
      .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_READY(ready),
      .RSP_VALID(rsp), .RSP_RDATA(rdata), .MUXED_ADDR_DATA_LOW_IN(lo_in),
      .MUXED_ADDR_DATA_LOW_OUT(lo_out), .MUXED_ADDR_DATA_LOW_OE_N(oe_n), .HIGH_ADDR_LINES(hi),
      .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .PROGRAM_FETCH_STROBE_N(ps_n),
      .ADDR_LATCH(ale), .RESET_OUT_N(rst_out_n), .TEST_REQ(TEST_REQ), .TEST_OP(TEST_OP),
      .TEST_ACK(ack), .TEST_DENY(deny), .TEST_LOCKED(locked), .NV_PROG_GO(nv),
      .ERASE_ALL_GO(er), .DBG_GO(dbg), .DBG_CMD(dbg_cmd));
   emb_companion_model far (.clk(CLK), .rst_n(rst_out_n), .latch(ale), .addr_hi(hi),
      .lo_out(lo_out), .lo_oe_n(oe_n), .rd_n(rd_n), .wr_n(wr_n), .fetch_n(ps_n), .wire_lo(lo_in));
   // Clock at 250 MHz
   always #2 CLK = ~CLK;
   // Verdict and end of run
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Hang guard: the whole sequence needs well under 1000 cycles
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         close_out();
      end
   end
   // One bus access; counts strobe cycles and checks lines while each strobe stands
   task automatic acc(input logic [1:0] sp, input logic w, input logic [15:0] a,
      input logic [7:0] d, input int er_n, input int ew_n, input int ep_n);
      int k, nl, nr, nw, np, bad;
      nl = 0; nr = 0; nw = 0; np = 0; bad = 0; k = 0;
      REQ_VALID = 1'b1; REQ_SPACE = sp; REQ_WRITE = w; REQ_ADDR = a; REQ_WDATA = d;
      while (ready !== 1'b1 && k < 20) begin
         @(negedge CLK);
         k++;
      end
      @(negedge CLK);
      REQ_VALID = 1'b0;
      k = 1;
      while (rsp !== 1'b1 && k < 20) begin
         if (ready !== 1'b0) bad++;
         if (ale === 1'b1) begin
            nl++;
            if (lo_out !== a[7:0] || oe_n !== 1'b0 || hi !== a[15:8]) bad++;
         end
         if (rd_n === 1'b0) begin
            nr++;
            if (ale !== 1'b0 || oe_n !== 1'b1) bad++;
         end
         if (wr_n === 1'b0) begin
            nw++;
            if (ale !== 1'b0 || oe_n !== 1'b0 || lo_out !== d) bad++;
         end
         if (ps_n === 1'b0) begin
            np++;
            if (ale !== 1'b0 || oe_n !== 1'b1) bad++;
         end
         @(negedge CLK);
         k++;
      end
      q = rdata;
      `CHK("answer cycle", (sp == emb_pkg::SPACE_INT) ? 3 : 8, k)
      `CHK("latch cycles", (sp == emb_pkg::SPACE_INT) ? 0 : 2, nl)
      `CHK("read strobe cycles", er_n, nr)
      `CHK("write strobe cycles", ew_n, nw)
      `CHK("fetch strobe cycles", ep_n, np)
      `CHK("line misuse", 0, bad)
   endtask
   // One test port operation and its one-cycle answer
   task automatic tport(input logic [2:0] op, input logic a, input logic g_nv,
      input logic g_er, input logic g_dbg);
      TEST_REQ = 1'b1; TEST_OP = op;
      @(negedge CLK);
      TEST_REQ = 1'b0;
      `CHK("test ack", a, ack)
      `CHK("test deny", ~a, deny)
      `CHK("nv program go", g_nv, nv)
      `CHK("erase go", g_er, er)
      `CHK("debug go", g_dbg, dbg)
      if (g_dbg) `CHK("debug command", op, dbg_cmd)
      @(negedge CLK);
   endtask
   // Reset holds every strobe idle and the companion die in reset
   task automatic t_reset();
      repeat (5) @(negedge CLK);
      `CHK("ready in reset", 1'b0, ready)
      `CHK("companion reset", 1'b0, rst_out_n)
      `CHK("strobes in reset", 3'h7, {rd_n, wr_n, ps_n})
      `CHK("latch in reset", 1'b0, ale)
      `CHK("lines released in reset", 1'b1, oe_n)
      RESET_N = 1'b1;
      @(negedge CLK);
      `CHK("ready after reset", 1'b1, ready)
      `CHK("companion released", 1'b1, rst_out_n)
   endtask
   // Program and data spaces are separate and chosen by their strobes
   task automatic t_spaces();
      acc(emb_pkg::SPACE_DATA, 1'b1, 16'h1234, 8'ha5, 0, 4, 0);
      acc(emb_pkg::SPACE_DATA, 1'b0, 16'h1234, 8'h00, 4, 0, 0);
      `CHK("data read back", 8'ha5, q)
      acc(emb_pkg::SPACE_PROG, 1'b0, 16'h1234, 8'h00, 0, 0, 4);
      `CHK("program fetch", 8'h7c, q)
      acc(emb_pkg::SPACE_PROG, 1'b1, 16'hfffe, 8'h11, 0, 0, 4);
      `CHK("program write is read", 8'h5b, q)
      acc(emb_pkg::SPACE_DATA, 1'b0, 16'hfffe, 8'h00, 4, 0, 0);
      `CHK("data space untouched", 8'h00, q)
      // Unused space code: address phase only, no strobe of any kind
      acc(2'h3, 1'b0, 16'h2222, 8'h00, 0, 0, 0);
   endtask
   // Internal SRAM shares low addresses with external data but never strobes
   task automatic t_internal();
      acc(emb_pkg::SPACE_DATA, 1'b1, 16'h0010, 8'h3c, 0, 4, 0);
      acc(emb_pkg::SPACE_INT, 1'b1, 16'h0010, 8'hc3, 0, 0, 0);
      acc(emb_pkg::SPACE_INT, 1'b0, 16'h0010, 8'h00, 0, 0, 0);
      `CHK("internal byte", 8'hc3, q)
      acc(emb_pkg::SPACE_DATA, 1'b0, 16'h0010, 8'h00, 4, 0, 0);
      `CHK("external byte kept", 8'h3c, q)
      acc(emb_pkg::SPACE_INT, 1'b1, 16'h017f, 8'h77, 0, 0, 0);
      acc(emb_pkg::SPACE_INT, 1'b0, 16'h017f, 8'h00, 0, 0, 0);
      `CHK("last internal byte", 8'h77, q)
      acc(emb_pkg::SPACE_INT, 1'b1, 16'h0180, 8'h99, 0, 0, 0);
      acc(emb_pkg::SPACE_INT, 1'b0, 16'h0180, 8'h00, 0, 0, 0);
      `CHK("beyond internal", 8'h00, q)
   endtask
   // Test port: every operation, lock refusal, erase as the only way out
   task automatic t_test_port();
      for (int op = 0; op < 5; op++) begin
         tport(3'(op), 1'b1, op == 0, 1'b0, op != 0);
      end
      tport(3'h7, 1'b0, 1'b0, 1'b0, 1'b0);
      tport(emb_pkg::OP_LOCK, 1'b1, 1'b0, 1'b0, 1'b0);
      `CHK("locked", 1'b1, locked)
      for (int op = 0; op < 5; op++) begin
         tport(3'(op), 1'b0, 1'b0, 1'b0, 1'b0);
      end
      tport(emb_pkg::OP_LOCK, 1'b0, 1'b0, 1'b0, 1'b0);
      `CHK("still locked", 1'b1, locked)
      tport(emb_pkg::OP_ERASE, 1'b1, 1'b0, 1'b1, 1'b0);
      `CHK("unlocked by erase", 1'b0, locked)
      tport(emb_pkg::OP_STEP, 1'b1, 1'b0, 1'b0, 1'b1);
   endtask
   // Main sequence
   initial begin
      t_reset();
      t_spaces();
      t_internal();
      t_test_port();
      close_out();
   end
endmodule
